// file: t1dl_regs.svh
`ifndef T1DL_REGS_SVH
`define T1DL_REGS_SVH

// ----------------------------------------------------------------
// register map (word index, byte address is index times four)
// ----------------------------------------------------------------
`define T1DL_ADR_W 14
`define T1DL_IDX_W 12
`define T1DL_IDX_LINK_SEL 12'h10a
`define T1DL_IDX_FRM_CTRL 12'h10b
`define T1DL_IDX_FRM_STAT 12'h110

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define T1DL_LINK_SEL_RST 8'h00
`define T1DL_LINK_SEL_MASK 8'h03
`define T1DL_FRM_CTRL_RST 8'h43
`define T1DL_RDAT_ZERO 32'h0000_0000
`define T1DL_BYTE_ZERO 24'h00_0000

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define T1DL_SRC_MSB 1
`define T1DL_SRC_LSB 0
`define T1DL_REFRAME_BIT 7
`define T1DL_CRC_BIT 6
`define T1DL_TOL_MSB 5
`define T1DL_TOL_LSB 3
`define T1DL_RNG_MSB 2
`define T1DL_RNG_LSB 0
`define T1DL_STAT_LOF_BIT 0
`define T1DL_STAT_INFRM_BIT 1
`define T1DL_STAT_CRCW_BIT 2

// ----------------------------------------------------------------
// source codes and loss-of-frame limits
// ----------------------------------------------------------------
`define T1DL_SRC_LAPD 2'b00
`define T1DL_SRC_SERIAL 2'b01
`define T1DL_SRC_OVERHEAD 2'b10
`define T1DL_SRC_ONES 2'b11
`define T1DL_LOF_ZERO 3'h0
`define T1DL_LOF_MIN 3'h1
`define T1DL_LAPD_NUM 3

`endif

// file: t1dl_pkg.sv
package t1dl_pkg;

  typedef enum logic [1:0] {
    T1DL_HUNT = 2'b00,
    T1DL_CRC_WAIT = 2'b01,
    T1DL_IN_FRAME = 2'b11
  } t1dl_sync_e;

  typedef struct packed {
    logic slot;
    logic lapd1_bit;
    logic slc96_bit;
    logic slc96_mode;
    logic serial_bit;
    logic overhead_bit;
    logic frame_bit;
  } t1dl_tx_in_s;

  typedef struct packed {
    logic fbit_valid;
    logic fbit_err;
    logic pattern_found;
    logic esf_mode;
    logic crc_valid;
    logic crc_ok;
  } t1dl_rx_in_s;

  typedef struct packed {
    logic reframe;
    logic crc_check_en;
    logic hunting;
    logic in_frame;
    logic lof;
  } t1dl_rx_out_s;

  typedef struct packed {
    logic [2:0] bits;
    logic [2:0] errs;
    logic hit;
  } t1dl_lof_s;

  typedef struct packed {
    logic [7:0] link_sel;
    logic [7:0] frm_ctrl;
    t1dl_sync_e sync;
    logic lof;
    logic reframe;
    logic ack;
    logic [31:0] rdat;
    logic tx_bit;
  } t1dl_state_s;

endpackage : t1dl_pkg

// file: t1dl_lof_mon.sv
`timescale 1ns/1ps
`default_nettype none
`include "t1dl_regs.svh"

module t1dl_lof_mon (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic fbit_valid_i,
  input wire logic fbit_err_i,
  input wire logic [2:0] tol_i,
  input wire logic [2:0] rng_i,
  output logic hit_o
);
  import t1dl_pkg::*;

  // ----------------------------------------------------------------
  // zero fields are lifted to one so the monitor never stalls
  // ----------------------------------------------------------------
  function automatic logic [2:0] t1dl_unblock(input logic [2:0] v);
    t1dl_unblock = (v == `T1DL_LOF_ZERO) ? `T1DL_LOF_MIN : v;
  endfunction : t1dl_unblock

  t1dl_lof_s st_q;
  t1dl_lof_s st_d;
  logic [2:0] eff_tol;
  logic [2:0] eff_rng;
  logic [2:0] errs_nx;
  logic [2:0] bits_nx;

  assign eff_tol = t1dl_unblock(tol_i);
  assign eff_rng = t1dl_unblock(rng_i);

  always_comb begin
    st_d = st_q;
    st_d.hit = 1'b0;
    errs_nx = st_q.errs + 3'(fbit_err_i);
    bits_nx = st_q.bits + 3'h1;
    if (!run_i) begin
      st_d.bits = 3'h0;
      st_d.errs = 3'h0;
    end else if (fbit_valid_i) begin
      if (errs_nx >= eff_tol) begin
        st_d.hit = 1'b1;
        st_d.bits = 3'h0;
        st_d.errs = 3'h0;
      end else if (bits_nx >= eff_rng) begin
        // window closed without enough errors: start a fresh one
        st_d.bits = 3'h0;
        st_d.errs = 3'h0;
      end else begin
        st_d.bits = bits_nx;
        st_d.errs = errs_nx;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hit_o = st_q.hit;

  AST_TOL_BLOCK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    run_i && fbit_valid_i && fbit_err_i && tol_i == `T1DL_LOF_ZERO |=> hit_o)
    else $error("zero tolerance not treated as one");

  AST_RNG_BLOCK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    run_i && fbit_valid_i && rng_i == `T1DL_LOF_ZERO |=> st_q.bits == 3'h0)
    else $error("zero range not treated as one");

endmodule : t1dl_lof_mon
`default_nettype wire

// file: t1dl_top.sv
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "t1dl_regs.svh"

module t1dl_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`T1DL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // transmit data link
  input wire t1dl_pkg::t1dl_tx_in_s tx_in_i,
  output logic tx_bit_o,
  output logic [`T1DL_LAPD_NUM-1:0] lapd_dl_rd_o,
  output logic [1:0] tx_link_source_sel_o,
  // receive framing control
  input wire t1dl_pkg::t1dl_rx_in_s rx_in_i,
  output t1dl_pkg::t1dl_rx_out_s rx_out_o
);
  import t1dl_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic t1dl_src_bit(input logic [1:0] sel, input t1dl_tx_in_s tin);
    t1dl_src_bit = 1'b1;
    unique case (sel)
      `T1DL_SRC_LAPD: t1dl_src_bit = tin.slc96_mode ? tin.slc96_bit : tin.lapd1_bit;
      `T1DL_SRC_SERIAL: t1dl_src_bit = tin.serial_bit;
      `T1DL_SRC_OVERHEAD: t1dl_src_bit = tin.overhead_bit;
      `T1DL_SRC_ONES: t1dl_src_bit = 1'b1;
    endcase
  endfunction : t1dl_src_bit

  function automatic logic t1dl_idx_is(input logic [`T1DL_ADR_W-1:0] adr,
                                       input logic [`T1DL_IDX_W-1:0] idx);
    t1dl_idx_is = (adr[`T1DL_ADR_W-1:2] == idx);
  endfunction : t1dl_idx_is

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  t1dl_state_s st_q;
  t1dl_state_s st_d;
  logic bus_req;
  logic wr_lane0;
  logic wr_link;
  logic wr_frm;
  logic [7:0] wr_byte;
  logic reframe_rise;
  logic lof_hit;
  logic monitor_run;
  logic crc_en;
  logic enter_frame;
  logic [1:0] src_sel;
  logic [7:0] stat_byte;

  assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_link = wr_lane0 && t1dl_idx_is(wb_adr_i, `T1DL_IDX_LINK_SEL);
  assign wr_frm = wr_lane0 && t1dl_idx_is(wb_adr_i, `T1DL_IDX_FRM_CTRL);
  assign wr_byte = wb_dat_i[7:0];
  assign reframe_rise = wr_frm && wr_byte[`T1DL_REFRAME_BIT]
                        && !st_q.frm_ctrl[`T1DL_REFRAME_BIT];
  assign src_sel = st_q.link_sel[`T1DL_SRC_MSB:`T1DL_SRC_LSB];
  assign crc_en = st_q.frm_ctrl[`T1DL_CRC_BIT];
  // error counting only makes sense while aligned
  assign monitor_run = (st_q.sync == T1DL_IN_FRAME) && !st_q.reframe;

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`T1DL_STAT_LOF_BIT] = st_q.lof;
    stat_byte[`T1DL_STAT_INFRM_BIT] = (st_q.sync == T1DL_IN_FRAME);
    stat_byte[`T1DL_STAT_CRCW_BIT] = (st_q.sync == T1DL_CRC_WAIT);
  end

  // ----------------------------------------------------------------
  // loss-of-frame window monitor
  // ----------------------------------------------------------------
  t1dl_lof_mon u_t1dl_lof_mon (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(monitor_run),
    .fbit_valid_i(rx_in_i.fbit_valid),
    .fbit_err_i(rx_in_i.fbit_err),
    .tol_i(st_q.frm_ctrl[`T1DL_TOL_MSB:`T1DL_TOL_LSB]),
    .rng_i(st_q.frm_ctrl[`T1DL_RNG_MSB:`T1DL_RNG_LSB]),
    .hit_o(lof_hit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.ack = bus_req;
    st_d.reframe = reframe_rise;
    enter_frame = 1'b0;

    // bus read data is captured with a read ack and held until the next read
    if (bus_req && !wb_we_i) begin
      st_d.rdat = `T1DL_RDAT_ZERO;
      if (t1dl_idx_is(wb_adr_i, `T1DL_IDX_LINK_SEL)) begin
        st_d.rdat = {`T1DL_BYTE_ZERO, st_q.link_sel};
      end else if (t1dl_idx_is(wb_adr_i, `T1DL_IDX_FRM_CTRL)) begin
        st_d.rdat = {`T1DL_BYTE_ZERO, st_q.frm_ctrl};
      end else if (t1dl_idx_is(wb_adr_i, `T1DL_IDX_FRM_STAT)) begin
        st_d.rdat = {`T1DL_BYTE_ZERO, stat_byte};
      end
    end

    // transmit: only the data-link slot is replaced
    st_d.tx_bit = tx_in_i.slot ? t1dl_src_bit(src_sel, tx_in_i) : tx_in_i.frame_bit;

    // receive alignment
    if (st_q.reframe || lof_hit) begin
      st_d.sync = T1DL_HUNT;
    end else begin
      unique case (st_q.sync)
        T1DL_HUNT: begin
          if (rx_in_i.pattern_found) begin
            if (crc_en && rx_in_i.esf_mode) begin
              st_d.sync = T1DL_CRC_WAIT;
            end else begin
              st_d.sync = T1DL_IN_FRAME;
            end
          end
        end
        T1DL_CRC_WAIT: begin
          if (rx_in_i.crc_valid) begin
            st_d.sync = rx_in_i.crc_ok ? T1DL_IN_FRAME : T1DL_HUNT;
          end
        end
        T1DL_IN_FRAME: begin
          st_d.sync = T1DL_IN_FRAME;
        end
        default: begin
          st_d.sync = T1DL_HUNT;
        end
      endcase
    end
    enter_frame = (st_d.sync == T1DL_IN_FRAME) && (st_q.sync != T1DL_IN_FRAME);

    // loss of frame: a fresh hit wins over the clear on regained alignment
    if (lof_hit) begin
      st_d.lof = 1'b1;
    end else if (enter_frame) begin
      st_d.lof = 1'b0;
    end

    // reframe request self-clears on sync, a software set in the same cycle wins
    if (enter_frame) begin
      st_d.frm_ctrl[`T1DL_REFRAME_BIT] = 1'b0;
    end
    if (wr_frm) begin
      st_d.frm_ctrl = wr_byte;
    end
    if (wr_link) begin
      st_d.link_sel = wr_byte & `T1DL_LINK_SEL_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.link_sel <= `T1DL_LINK_SEL_RST;
      st_q.frm_ctrl <= `T1DL_FRM_CTRL_RST;
      st_q.sync <= T1DL_HUNT;
      st_q.lof <= 1'b0;
      st_q.reframe <= 1'b0;
      st_q.ack <= 1'b0;
      st_q.rdat <= `T1DL_RDAT_ZERO;
      st_q.tx_bit <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdat;
  assign tx_bit_o = st_q.tx_bit;
  assign tx_link_source_sel_o = src_sel;

  // the other controllers have no path into the data link at all
  genvar gi;
  generate
    for (gi = 0; gi < `T1DL_LAPD_NUM; gi++) begin : g_lapd
      if (gi == 0) begin : g_first
        assign lapd_dl_rd_o[gi] = tx_in_i.slot && (src_sel == `T1DL_SRC_LAPD)
                                  && !tx_in_i.slc96_mode;
      end else begin : g_other
        assign lapd_dl_rd_o[gi] = 1'b0;
      end
    end
  endgenerate

  assign rx_out_o.reframe = st_q.reframe;
  assign rx_out_o.crc_check_en = crc_en;
  assign rx_out_o.hunting = (st_q.sync == T1DL_HUNT);
  assign rx_out_o.in_frame = (st_q.sync == T1DL_IN_FRAME);
  assign rx_out_o.lof = st_q.lof;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  AST_SRC_LAPD: assert property (
    tx_in_i.slot && src_sel == `T1DL_SRC_LAPD
    |=> tx_bit_o == ($past(tx_in_i.slc96_mode) ? $past(tx_in_i.slc96_bit)
                                               : $past(tx_in_i.lapd1_bit)))
    else $error("data link bit not from first controller or slc96");

  AST_LAPD_ONLY_FIRST: assert property (
    lapd_dl_rd_o[`T1DL_LAPD_NUM-1:1] == '0 && (!lapd_dl_rd_o[0] || tx_in_i.slot))
    else $error("controller other than first reads data link");

  AST_LAPD_RD_FIRST: assert property (
    lapd_dl_rd_o[0] == (tx_in_i.slot && src_sel == `T1DL_SRC_LAPD && !tx_in_i.slc96_mode))
    else $error("first controller read strobe wrong");

  // outside the data-link slot the frame bit must pass untouched, or the
  // source select would corrupt payload and framing
  AST_FRAME_PASS: assert property (
    !tx_in_i.slot |=> tx_bit_o == $past(tx_in_i.frame_bit))
    else $error("non data-link bit altered");

  AST_SRC_SERIAL: assert property (
    tx_in_i.slot && src_sel == `T1DL_SRC_SERIAL |=> tx_bit_o == $past(tx_in_i.serial_bit))
    else $error("data link bit not from serial input");

  AST_SRC_OVERHEAD: assert property (
    tx_in_i.slot && src_sel == `T1DL_SRC_OVERHEAD
    |=> tx_bit_o == $past(tx_in_i.overhead_bit))
    else $error("data link bit not from overhead input");

  AST_SRC_ONES: assert property (
    tx_in_i.slot && src_sel == `T1DL_SRC_ONES |=> tx_bit_o)
    else $error("data link bit not forced high");

  AST_REFRAME_RESTART: assert property (
    reframe_rise |=> rx_out_o.reframe ##1 rx_out_o.hunting)
    else $error("reframe edge did not restart sync");

  AST_REFRAME_CLEAR: assert property (
    $rose(rx_out_o.in_frame) && !$past(wr_frm)
    |-> !st_q.frm_ctrl[`T1DL_REFRAME_BIT])
    else $error("reframe bit not cleared at sync");

  AST_CRC_WAIT: assert property (
    rx_out_o.hunting && !st_q.reframe && !lof_hit && rx_in_i.pattern_found
    |=> (st_q.sync == T1DL_CRC_WAIT) == $past(crc_en && rx_in_i.esf_mode))
    else $error("crc gating of alignment wrong");

  AST_LOF_DECLARE: assert property (
    lof_hit |=> rx_out_o.lof && rx_out_o.hunting)
    else $error("loss of frame not declared");

  AST_LOF_HOLD: assert property (
    rx_out_o.lof && !rx_out_o.in_frame && !enter_frame |=> rx_out_o.lof)
    else $error("loss of frame dropped before alignment");

  AST_WB_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle");

  // ----------------------------------------------------------------
  // register side checks
  // ----------------------------------------------------------------
  // software may poll the data word long after the ack, so it must not drift
  AST_WB_RDAT_HOLD: assert property (
    !(bus_req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");

  AST_LINK_SEL_RSVD: assert property (
    (st_q.link_sel & ~`T1DL_LINK_SEL_MASK) == 8'h00)
    else $error("reserved link select bits stored");

  // ----------------------------------------------------------------
  // receive alignment checks
  // ----------------------------------------------------------------
  AST_REFRAME_PULSE: assert property (
    rx_out_o.reframe |=> !rx_out_o.reframe)
    else $error("reframe pulse longer than one cycle");

  // the request bit must survive until sync, or a slow framer would lose it
  AST_REFRAME_KEEP: assert property (
    st_q.frm_ctrl[`T1DL_REFRAME_BIT] && !enter_frame && !wr_frm
    |=> st_q.frm_ctrl[`T1DL_REFRAME_BIT])
    else $error("reframe bit cleared before sync");

  AST_CRC_BYPASS: assert property (
    rx_out_o.hunting && !st_q.reframe && !lof_hit && rx_in_i.pattern_found
    && !(crc_en && rx_in_i.esf_mode) |=> rx_out_o.in_frame)
    else $error("alignment waited for crc while not required");

  AST_CRC_RESULT: assert property (
    st_q.sync == T1DL_CRC_WAIT && !st_q.reframe && !lof_hit && rx_in_i.crc_valid
    |=> rx_out_o.in_frame == $past(rx_in_i.crc_ok))
    else $error("crc result not applied to alignment");

  AST_LOF_SET_ONLY_HIT: assert property (
    !rx_out_o.lof && !lof_hit |=> !rx_out_o.lof)
    else $error("loss of frame without window hit");

  // counting outside alignment would declare a defect on a line still hunting
  AST_LOF_IDLE: assert property (
    !monitor_run |=> !lof_hit)
    else $error("window monitor ran while not aligned");

  AST_LOF_CLEAR: assert property (
    rx_out_o.lof && enter_frame && !lof_hit |=> !rx_out_o.lof)
    else $error("loss of frame kept after alignment");

  COV_LOF_RECOVER: cover property (lof_hit ##[1:200] $rose(rx_out_o.in_frame));
  COV_CRC_PATH: cover property (st_q.sync == T1DL_CRC_WAIT ##1 rx_out_o.in_frame);
  COV_REFRAME: cover property (reframe_rise ##[1:50] $rose(rx_out_o.in_frame));
  COV_OVERHEAD: cover property (tx_in_i.slot && src_sel == `T1DL_SRC_OVERHEAD);
  COV_CRC_BYPASS: cover property (rx_out_o.hunting && rx_in_i.pattern_found
                                  && crc_en && !rx_in_i.esf_mode);

endmodule : t1dl_top
`default_nettype wire

// file: t1dl_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module t1dl_line_model
  import t1dl_pkg::*;
(
  input wire logic [6:0] tx_pat_i,
  input wire logic [2:0] ev_i,
  input wire logic esf_i,
  output var t1dl_pkg::t1dl_tx_in_s tx_in_o,
  output var t1dl_pkg::t1dl_rx_in_s rx_in_o
);
  // ----------------------------------------------------------------
  // local link sources and line events
  // ----------------------------------------------------------------
  // events are one-cycle strobes; code 0 leaves every strobe low, so nothing
  // stale from the last event can be mistaken for a new one
  always_comb begin
    tx_in_o = t1dl_tx_in_s'(tx_pat_i);
    rx_in_o = '0;
    rx_in_o.esf_mode = esf_i;
    rx_in_o.pattern_found = (ev_i == 3'h1);
    rx_in_o.crc_valid = (ev_i == 3'h2) || (ev_i == 3'h3);
    rx_in_o.crc_ok = (ev_i == 3'h2);
    rx_in_o.fbit_valid = (ev_i == 3'h4) || (ev_i == 3'h5);
    rx_in_o.fbit_err = (ev_i == 3'h5);
  end
endmodule : t1dl_line_model

`default_nettype wire

// file: t1_datalink_src_and_frame_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "t1dl_regs.svh"

module t1_datalink_src_and_frame_ctrl_tb_top;
  import t1dl_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [13:0] wb_adr = 14'h0000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  logic [6:0] tx_pat = 7'h00;
  logic [2:0] ev = 3'h0;
  logic esf = 1'b0;
  t1dl_tx_in_s tx_in;
  t1dl_rx_in_s rx_in;
  t1dl_rx_out_s rx_out;
  logic tx_bit;
  logic [2:0] lapd_rd;
  logic [1:0] src_o;
  int fail_count = 0;
  int checks_done = 0;
  int neg_cnt = 0;
  int reframe_cnt = 0;
  logic [16:0] lfsr_q = 17'h167b5;
  logic [31:0] rd_q[$];
  logic tx_e_q[$];
  int tx_t_q[$];

  initial forever #2 clk_sys_i = ~clk_sys_i;

  t1dl_line_model u_t1dl_line_model (.tx_pat_i(tx_pat), .ev_i(ev), .esf_i(esf),
    .tx_in_o(tx_in), .rx_in_o(rx_in));

  t1dl_top u_t1dl_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .tx_in_i(tx_in),
    .tx_bit_o(tx_bit), .lapd_dl_rd_o(lapd_rd), .tx_link_source_sel_o(src_o),
    .rx_in_i(rx_in), .rx_out_o(rx_out));

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_next

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wb_xfer(input logic w, input logic [11:0] idx, input logic [7:0] d,
                         input logic [3:0] s, input logic [7:0] exp);
    if (!w) rd_q.push_back({24'h00_0000, exp});
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_sel <= s;
    wb_dat <= {24'h00_0000, d};
    do begin
      @(posedge clk_sys_i);
    end while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d, 4'hf, 8'h00);
  endtask : wr

  task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00, 4'hf, exp);
  endtask : rd

  task automatic line_ev(input logic [2:0] c);
    @(posedge clk_sys_i);
    ev <= c;
    @(posedge clk_sys_i);
    ev <= 3'h0;
  endtask : line_ev

  task automatic run_tx(input logic [1:0] code, input int n);
    t1dl_tx_in_s v;
    logic e;
    wr(`T1DL_IDX_LINK_SEL, {6'h00, code});
    chk_reg("source select", {30'h0, code}, {30'h0, src_o});
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      lfsr_q = lfsr_next(lfsr_q);
      v = t1dl_tx_in_s'(lfsr_q[6:0]);
      tx_pat <= lfsr_q[6:0];
      if (!v.slot) e = v.frame_bit;
      else case (code)
        `T1DL_SRC_LAPD: e = v.slc96_mode ? v.slc96_bit : v.lapd1_bit;
        `T1DL_SRC_SERIAL: e = v.serial_bit;
        `T1DL_SRC_OVERHEAD: e = v.overhead_bit;
        default: e = 1'b1;
      endcase
      tx_e_q.push_back(e);
      tx_t_q.push_back(neg_cnt);
      @(negedge clk_sys_i);
      chk_bit("lapd one read", v.slot && code == `T1DL_SRC_LAPD && !v.slc96_mode, lapd_rd[0]);
      chk_reg("other lapd reads", 32'h0, {30'h0, lapd_rd[2:1]});
    end
  endtask : run_tx

  // ----------------------------------------------------------------
  // result monitors
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0) begin
      chk_reg("read data", rd_q.pop_front(), wb_dat_o);
    end
  end

  // the outbound bit is registered, so it is judged one falling edge later
  always @(negedge clk_sys_i) begin
    if (tx_t_q.size() > 0 && tx_t_q[0] + 1 == neg_cnt) begin
      void'(tx_t_q.pop_front());
      chk_bit("tx bit", tx_e_q.pop_front(), tx_bit);
    end
    if (rx_out.reframe === 1'b1) reframe_cnt++;
    neg_cnt++;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`T1DL_IDX_LINK_SEL, 8'h00);
    rd(`T1DL_IDX_FRM_CTRL, 8'h43);
    rd(`T1DL_IDX_FRM_STAT, 8'h00);
    rd(12'h000, 8'h00);
    wb_xfer(1'b1, `T1DL_IDX_LINK_SEL, 8'h03, 4'he, 8'h00);
    rd(`T1DL_IDX_LINK_SEL, 8'h00);
    wr(`T1DL_IDX_LINK_SEL, 8'hff);
    rd(`T1DL_IDX_LINK_SEL, 8'h03);
    $display("test registers done");
    for (int c = 0; c < 4; c++) run_tx(c[1:0], 24);
    $display("test link source done");
    @(posedge clk_sys_i);
    esf <= 1'b1;
    wr(`T1DL_IDX_FRM_CTRL, 8'h55);
    line_ev(3'h1);
    rd(`T1DL_IDX_FRM_STAT, 8'h04);
    line_ev(3'h3);
    rd(`T1DL_IDX_FRM_STAT, 8'h00);
    line_ev(3'h1);
    line_ev(3'h2);
    rd(`T1DL_IDX_FRM_STAT, 8'h02);
    wr(`T1DL_IDX_FRM_CTRL, 8'hd5);
    repeat (2) @(negedge clk_sys_i);
    chk_bit("hunting", 1'b1, rx_out.hunting);
    rd(`T1DL_IDX_FRM_CTRL, 8'hd5);
    line_ev(3'h1);
    line_ev(3'h2);
    rd(`T1DL_IDX_FRM_CTRL, 8'h55);
    wr(`T1DL_IDX_FRM_CTRL, 8'h15);
    chk_bit("crc enable", 1'b0, rx_out.crc_check_en);
    wr(`T1DL_IDX_FRM_CTRL, 8'h95);
    line_ev(3'h1);
    rd(`T1DL_IDX_FRM_STAT, 8'h02);
    $display("test reframe done");
    repeat (4) line_ev(3'h4);
    line_ev(3'h5);
    line_ev(3'h5);
    rd(`T1DL_IDX_FRM_STAT, 8'h02);
    line_ev(3'h5);
    rd(`T1DL_IDX_FRM_STAT, 8'h01);
    chk_bit("lof flag", 1'b1, rx_out.lof);
    line_ev(3'h4);
    rd(`T1DL_IDX_FRM_STAT, 8'h01);
    line_ev(3'h1);
    rd(`T1DL_IDX_FRM_STAT, 8'h02);
    chk_bit("lof flag", 1'b0, rx_out.lof);
    chk_bit("in frame", 1'b1, rx_out.in_frame);
    wr(`T1DL_IDX_FRM_CTRL, 8'h00);
    line_ev(3'h5);
    rd(`T1DL_IDX_FRM_STAT, 8'h01);
    rd(`T1DL_IDX_FRM_CTRL, 8'h00);
    @(posedge clk_sys_i);
    esf <= 1'b0;
    wr(`T1DL_IDX_FRM_CTRL, 8'h55);
    line_ev(3'h1);
    rd(`T1DL_IDX_FRM_STAT, 8'h02);
    chk_reg("reframe pulses", 32'h0000_0002, reframe_cnt);
    $display("test loss of frame done");
    stop_test();
  end
endmodule : t1_datalink_src_and_frame_ctrl_tb_top

`default_nettype wire
